// ==== src/pcc_defs.svh ====
/*
 pwm channel counter: register offsets, field positions, reset values.
 assumes inclusion by bare name from every design file that needs it.
*/
`ifndef PCC_DEFS_SVH
`define PCC_DEFS_SVH
`define PCC_OFF_ENA 8'h00
`define PCC_OFF_DIS 8'h04
`define PCC_OFF_STAT 8'h08
`define PCC_OFF_MODE 8'h0c
`define PCC_OFF_PRD 8'h10
`define PCC_OFF_UPD 8'h14
`define PCC_OFF_CNT 8'h18
`define PCC_OFF_ISR 8'h1c
`define PCC_OFF_IMR 8'h20
`define PCC_BIT_CENTER 0
`define PCC_BIT_PEND 0
`define PCC_RST_PRD 16'h0000
`define PCC_CNT_FIRST 16'h0000
`define PCC_CNT_RESTART 16'h0001
`endif

// ==== src/pcc_pkg.sv ====
/*
 pwm channel counter package: shared types.
 assumes nothing beyond a systemverilog compiler.
*/
`default_nettype none
package pcc_pkg;
   typedef logic [15:0] pcc_cnt_t;
   typedef enum logic [2:0] {
      PCC_IDLE = 3'b001,
      PCC_RUN = 3'b010,
      PCC_DRAIN = 3'b100
   } pcc_state_e;
endpackage : pcc_pkg
`default_nettype wire

// ==== src/pcc_ctr_if.sv ====
/*
 pwm channel counter: link between register file and counter core.
 assumes one clock domain shared by both ends.
*/
`default_nettype none
interface pcc_ctr_if;
   logic run;
   logic [15:0] period;
   logic [15:0] count;
   logic wrap;
   modport regs (output run, output period, input count, input wrap);
   modport core (input run, input period, output count, output wrap);
endinterface : pcc_ctr_if
`default_nettype wire

// ==== src/pcc_core.sv ====
/*
 pwm channel counter core: up counter with period wrap.
 assumes run and period come from the register file on the same clock.
*/
`default_nettype none
`include "pcc_defs.svh"
module pcc_core (
   input wire logic core_clk_in,
   input wire logic nrst_in,
   pcc_ctr_if.core ctr
);
   pcc_pkg::pcc_cnt_t count;
   pcc_pkg::pcc_cnt_t next_count;
   logic wrap;
   logic next_wrap;

   // count up, wrap at period; first run starts at zero
   always_comb begin
      next_count = count;
      next_wrap = 1'b0;
      if (!ctr.run) begin
         next_count = `PCC_CNT_FIRST;
      end else if (count >= ctr.period) begin
         next_count = `PCC_CNT_RESTART;
         next_wrap = 1'b1;
      end else begin
         next_count = count + 16'h0001;
      end
   end

   // register counter state
   always_ff @(posedge core_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         count <= `PCC_CNT_FIRST;
         wrap <= 1'b0;
      end else begin
         count <= next_count;
         wrap <= next_wrap;
      end
   end

   assign ctr.count = count;
   assign ctr.wrap = wrap;
endmodule : pcc_core
`default_nettype wire

// ==== src/pcc_top.sv ====
/*
 pwm channel counter top: apb register file, enable state, interrupt.
 assumes apb master on core_clk_in, 32-bit data, word-aligned offsets.
*/
`default_nettype none
`include "pcc_defs.svh"
module pcc_top (
   input wire logic core_clk_in,
   input wire logic nrst_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [7:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   output logic irq_out,
   output logic wrap_out
);
   pcc_ctr_if ctr ();

   pcc_pkg::pcc_state_e state;
   pcc_pkg::pcc_state_e next_state;
   logic center_align_select;
   logic next_center_align_select;
   logic [15:0] channel_period_reg;
   logic [15:0] next_channel_period_reg;
   logic [15:0] period_update_reg;
   logic [15:0] next_period_update_reg;
   logic upd_pend;
   logic next_upd_pend;
   logic isr;
   logic next_isr;
   logic imr;
   logic next_imr;
   logic [31:0] next_prdata;
   logic next_pready;
   logic next_pslverr;
   logic next_irq;
   logic next_wrap_out;
   logic acc;
   logic wr;
   logic known;
   logic wr_ena;
   logic wr_dis;
   logic channel_enable_status_bit;

   pcc_core u_core (
      .core_clk_in(core_clk_in),
      .nrst_in(nrst_in),
      .ctr(ctr)
   );

   // apb access phase, answered in the same cycle pready rises
   assign acc = psel_in && penable_in && !pready_out;
   assign wr = acc && pwrite_in;
   assign wr_ena = wr && paddr_in == `PCC_OFF_ENA && pwdata_in[0];
   assign wr_dis = wr && paddr_in == `PCC_OFF_DIS && pwdata_in[0];
   assign channel_enable_status_bit = state != pcc_pkg::PCC_IDLE;
   // counter keeps running while the enabled status lingers after disable
   assign ctr.run = state != pcc_pkg::PCC_IDLE;
   assign ctr.period = channel_period_reg;

   always_comb begin
      unique case (paddr_in)
         `PCC_OFF_ENA, `PCC_OFF_DIS, `PCC_OFF_STAT, `PCC_OFF_MODE,
         `PCC_OFF_PRD, `PCC_OFF_UPD, `PCC_OFF_CNT, `PCC_OFF_ISR,
         `PCC_OFF_IMR: known = 1'b1;
         default: known = 1'b0;
      endcase
   end

   // channel enable state: status lingers until the period ends
   always_comb begin
      next_state = state;
      unique case (state)
         pcc_pkg::PCC_IDLE: begin
            if (wr_ena) next_state = pcc_pkg::PCC_RUN;
         end
         pcc_pkg::PCC_RUN: begin
            if (wr_dis) next_state = pcc_pkg::PCC_DRAIN;
         end
         pcc_pkg::PCC_DRAIN: begin
            if (wr_ena) next_state = pcc_pkg::PCC_RUN;
            else if (ctr.wrap) next_state = pcc_pkg::PCC_IDLE;
         end
      endcase
   end

   // configuration and period update
   always_comb begin
      next_center_align_select = center_align_select;
      next_channel_period_reg = channel_period_reg;
      next_period_update_reg = period_update_reg;
      next_upd_pend = upd_pend;
      next_imr = imr;
      if (wr && paddr_in == `PCC_OFF_MODE) begin
         next_center_align_select = pwdata_in[`PCC_BIT_CENTER];
      end
      if (wr && paddr_in == `PCC_OFF_IMR) begin
         next_imr = pwdata_in[`PCC_BIT_PEND];
      end
      if (upd_pend && (ctr.wrap || !ctr.run)) begin
         next_channel_period_reg = period_update_reg;
         next_upd_pend = 1'b0;
      end
      if (wr && paddr_in == `PCC_OFF_PRD) begin
         next_channel_period_reg = pwdata_in[15:0]; // zero allowed here
      end
      if (wr && paddr_in == `PCC_OFF_UPD && pwdata_in[15:0] != 16'h0000) begin
         next_period_update_reg = pwdata_in[15:0];
         next_upd_pend = 1'b1;
      end
   end

   // sticky channel event: wrap, or enable in centre-aligned mode
   always_comb begin
      next_isr = isr;
      if (wr && paddr_in == `PCC_OFF_ISR && pwdata_in[`PCC_BIT_PEND]) begin
         next_isr = 1'b0;
      end
      if (ctr.wrap) next_isr = 1'b1;
      if (wr_ena && center_align_select) next_isr = 1'b1;
      next_irq = next_isr && next_imr;
      next_wrap_out = ctr.wrap;
   end

   // apb answer and read mux
   always_comb begin
      next_pready = acc;
      next_pslverr = acc && !known;
      next_prdata = 32'h0000_0000;
      if (acc && !pwrite_in) begin
         unique case (paddr_in)
            `PCC_OFF_STAT: next_prdata = {31'h0, channel_enable_status_bit};
            `PCC_OFF_MODE: next_prdata = {31'h0, center_align_select};
            `PCC_OFF_PRD: next_prdata = {16'h0, channel_period_reg};
            `PCC_OFF_UPD: next_prdata = {16'h0, period_update_reg};
            `PCC_OFF_CNT: next_prdata = {16'h0, ctr.count};
            `PCC_OFF_ISR: next_prdata = {31'h0, isr};
            `PCC_OFF_IMR: next_prdata = {31'h0, imr};
            default: next_prdata = 32'h0000_0000;
         endcase
      end
   end

   // register all state
   always_ff @(posedge core_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         state <= pcc_pkg::PCC_IDLE;
         center_align_select <= 1'b0;
         channel_period_reg <= `PCC_RST_PRD;
         period_update_reg <= `PCC_RST_PRD;
         upd_pend <= 1'b0;
         isr <= 1'b0;
         imr <= 1'b0;
         prdata_out <= 32'h0000_0000;
         pready_out <= 1'b0;
         pslverr_out <= 1'b0;
         irq_out <= 1'b0;
         wrap_out <= 1'b0;
      end else begin
         state <= next_state;
         center_align_select <= next_center_align_select;
         channel_period_reg <= next_channel_period_reg;
         period_update_reg <= next_period_update_reg;
         upd_pend <= next_upd_pend;
         isr <= next_isr;
         imr <= next_imr;
         prdata_out <= next_prdata;
         pready_out <= next_pready;
         pslverr_out <= next_pslverr;
         irq_out <= next_irq;
         wrap_out <= next_wrap_out;
      end
   end
endmodule : pcc_top
`default_nettype wire

// ==== tb/pcc_top_properties.sv ====
/*
 pcc_top port checker: apb answer timing and wrap start.
 assumes one clock and an async active-low reset.
*/
`default_nettype none
`include "pcc_defs.svh"
module pcc_top_properties (
   input wire logic core_clk_in,
   input wire logic nrst_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [7:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   input wire logic [31:0] prdata_out,
   input wire logic pready_out,
   input wire logic pslverr_out,
   input wire logic irq_out,
   input wire logic wrap_out
);
   logic seen;
   logic next_seen;
   wire logic acc = psel_in && penable_in && !pready_out;
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (!nrst_in);
   // note an enable request since reset
   always_comb begin
      next_seen = seen;
      if (psel_in && penable_in && pwrite_in && paddr_in == `PCC_OFF_ENA)
         next_seen = 1'b1;
   end
   always_ff @(posedge core_clk_in or negedge nrst_in) begin
      if (!nrst_in)
         seen <= 1'b0;
      else
         seen <= next_seen;
   end
   // answer timing and read data shape
   a_ready_wait: assert property (acc |=> pready_out) else $error("no ready");
   a_ready_pulse: assert property (pready_out |=> !pready_out)
      else $error("ready held");
   a_idle_quiet: assert property (!psel_in |=> !pready_out)
      else $error("stray ready");
   a_err_ready: assert property (pslverr_out |-> pready_out)
      else $error("lone error");
   a_rdata_idle: assert property (!pready_out |-> prdata_out == 32'h0)
      else $error("data outside answer");
   a_err_zero: assert property (pslverr_out |-> prdata_out == 32'h0)
      else $error("data with error");
   a_stat_bit: assert property (pready_out && paddr_in == `PCC_OFF_STAT
      |-> prdata_out[31:1] == 31'h0) else $error("status width");
   a_wrap_run: assert property (!seen |-> !wrap_out)
      else $error("wrap before enable");
   c_error: cover property (pslverr_out);
   c_irq: cover property (irq_out);
   c_wrap: cover property (seen && wrap_out);
endmodule : pcc_top_properties
bind pcc_top pcc_top_properties i_props (.*);
`default_nettype wire

// ==== tb/pcc_top_tb_top.sv ====
/*
 pcc_top bench: apb driver, read scoreboard, period timing.
 assumes one wait state apb and a 50 MHz clock.
*/
`default_nettype none
`include "pcc_defs.svh"
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin err_total++; \
   $display("unexpected t=%0t got %h exp %h", $time, a, e); end end
module pcc_top_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic core_clk_in = 1'b0;
   logic nrst_in = 1'b0;
   logic psel_in = 1'b0;
   logic penable_in = 1'b0;
   logic pwrite_in = 1'b0;
   logic [7:0] paddr_in = 8'h00;
   logic [31:0] pwdata_in = 32'h0;
   logic [31:0] prdata_out;
   logic pready_out, pslverr_out, irq_out, wrap_out;
   logic [32:0] exp_q[$];
   logic [32:0] e;
   int err_total = 0;
   int cmp_count = 0;
   int p, d0, d1;
   pcc_top i_dut (.*);
   // clock
   always #10 core_clk_in = ~core_clk_in;
   // oldest note against each read answer
   always @(posedge core_clk_in) begin
      if (pready_out === 1'b1 && pwrite_in === 1'b0 && exp_q.size() > 0) begin
         e = exp_q.pop_front();
         `CHK({pslverr_out, prdata_out}, e)
      end
   end
   task automatic print_verdict(input int bad);
      err_total += bad;
      $display("compares %0d errors %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : print_verdict
   // one apb transfer; a read leaves a note
   task automatic apb(input logic w, input logic [7:0] a,
         input logic [31:0] d, input logic [32:0] x = 33'h0);
      int n;
      n = 0;
      if (!w)
         exp_q.push_back(x);
      psel_in <= 1'b1;
      pwrite_in <= w;
      paddr_in <= a;
      pwdata_in <= d;
      @(posedge core_clk_in);
      penable_in <= 1'b1;
      do begin
         @(posedge core_clk_in);
         n++;
      end while (pready_out !== 1'b1 && n < 20);
      if (n >= 20)
         print_verdict(1);
      psel_in <= 1'b0;
      penable_in <= 1'b0;
      @(posedge core_clk_in);
   endtask : apb
   // cycles until the next period end
   task automatic wait_wrap(output int c);
      c = 0;
      do begin
         @(posedge core_clk_in);
         c++;
      end while (wrap_out !== 1'b1 && c < 500);
      if (c >= 500)
         print_verdict(1);
   endtask : wait_wrap
   // main sequence
   initial begin
      void'($urandom(38));
      p = $urandom_range(20, 12);
      repeat (8) @(posedge core_clk_in);
      nrst_in <= 1'b1;
      @(posedge core_clk_in);
      apb(0, `PCC_OFF_PRD, 32'h0, {1'b0, 16'h0, `PCC_RST_PRD});
      apb(0, `PCC_OFF_STAT, 32'h0);
      apb(0, 8'h30, 32'h0, {1'b1, 32'h0});
      apb(1, `PCC_OFF_PRD, 32'h0);
      apb(0, `PCC_OFF_PRD, 32'h0);
      apb(1, `PCC_OFF_UPD, 32'(p));
      apb(1, `PCC_OFF_UPD, 32'h0);
      apb(0, `PCC_OFF_PRD, 32'h0, 33'(p));
      apb(1, `PCC_OFF_ENA, 32'h1);
      wait_wrap(d0);
      wait_wrap(d1);
      // first period is one cycle longer; bus tail and wrap delay cancel
      `CHK(d0, p + 1)
      `CHK(d1, p)
      apb(1, `PCC_OFF_UPD, 32'h0);
      wait_wrap(d1);
      wait_wrap(d1);
      `CHK(d1, p)
      apb(1, `PCC_OFF_DIS, 32'h1);
      apb(0, `PCC_OFF_STAT, 32'h0, 33'h1);
      wait_wrap(d1);
      apb(0, `PCC_OFF_STAT, 32'h0, 33'h0);
      apb(1, `PCC_OFF_PRD, 32'd300);
      apb(1, `PCC_OFF_ISR, 32'h1);
      apb(1, `PCC_OFF_MODE, 32'h1);
      apb(1, `PCC_OFF_ENA, 32'h1);
      apb(0, `PCC_OFF_ISR, 32'h0, 33'h1);
      apb(1, `PCC_OFF_ISR, 32'h1);
      apb(0, `PCC_OFF_ISR, 32'h0, 33'h0);
      apb(1, `PCC_OFF_IMR, 32'h1);
      `CHK(irq_out, 1'b0)
      wait_wrap(d1);
      @(posedge core_clk_in);
      `CHK(irq_out, 1'b1)
      apb(1, `PCC_OFF_IMR, 32'h0);
      `CHK(irq_out, 1'b0)
      repeat (3) @(posedge core_clk_in);
      print_verdict(exp_q.size());
   end
endmodule : pcc_top_tb_top
`default_nettype wire
